// [src/jcpp_pkg.sv]
// types shared by the serial configuration port
// assumes jcpp_regs.svh is on the include path
`include "jcpp_regs.svh"

package jcpp_pkg;

	// ----------------------------------------------------------------------
	// controller states, data path selection, nonvolatile operations
	// ----------------------------------------------------------------------
	typedef enum logic [3:0] {
		st_reset, st_idle,
		st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pau_dr, st_ex2_dr, st_upd_dr,
		st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pau_ir, st_ex2_ir, st_upd_ir
	} jcpp_st_e;

	typedef enum logic [2:0] {sel_bypass, sel_id, sel_sig, sel_addr, sel_data} jcpp_dsel_e;

	typedef enum logic [2:0] {op_none, op_prog, op_lock, op_erase, op_sig, op_verify} jcpp_op_e;

endpackage

// [src/jcpp_regs.svh]
// constants of the serial configuration port: instruction codes, register lengths,
// reset values and timing counts; included by the package and the port logic
`ifndef JCPP_REGS_SVH
`define JCPP_REGS_SVH

// --------------------------------------------------------------------------
// instruction register
// --------------------------------------------------------------------------
`define JCPP_IR_W          8
`define JCPP_INS_BYPASS    8'hFF
`define JCPP_INS_EXTEST    8'h00
`define JCPP_INS_SAMPLE    8'h1C
`define JCPP_INS_IDCODE    8'h16
`define JCPP_INS_PROG_EN   8'h15
`define JCPP_INS_PROG_DIS  8'h1E
`define JCPP_INS_LOCK_PROG 8'h09
`define JCPP_INS_ERASE     8'h03
`define JCPP_INS_ADDR_SH   8'h01
`define JCPP_INS_DATA_SH   8'h02
`define JCPP_INS_PROGRAM   8'h07
`define JCPP_INS_VERIFY    8'h0A
`define JCPP_INS_SIG_PROG  8'h1A
`define JCPP_INS_SIG_READ  8'h17

// --------------------------------------------------------------------------
// data register lengths and reset values
// --------------------------------------------------------------------------
`define JCPP_ID_LEN        32
`define JCPP_SIG_LEN       32
`define JCPP_SIG_ERASED    32'hFFFFFFFF
`define JCPP_ERASED_BIT    1'b1
`define JCPP_LOCK_RST      1'b0

// --------------------------------------------------------------------------
// timing: nonvolatile op fires on the rising edge after this many spent in run-test/idle
// --------------------------------------------------------------------------
`define JCPP_RTI_FIRE_CNT  2'h1
`define JCPP_RTI_SAT_CNT   2'h2

`endif

// [src/jcpp_sync.sv]
// two-flop synchroniser for levels and toggles
// assumes d is held steady for at least two edges of clk
`timescale 1ns/1ns
`default_nettype none

module jcpp_sync #(
	parameter int WIDTH = 1
) (
	// clock of the receiving domain
	input  wire logic             clk,
	// level from the far domain and its safe copy
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;

	// first stage is read by the second stage only
	always_ff @(posedge clk) begin
		meta_r <= d;
		q      <= meta_r;
	end

endmodule // jcpp_sync

`default_nettype wire

// [src/jcpp_tap.sv]
// serial test access port that configures the device and holds its nonvolatile cells
// assumes tck is the link clock from the programming host and clk a free running 10 MHz
// Behaviour
// - sixteen-state controller stepped by tck, next state chosen by tms
// - tdi and tms sampled on rising tck; tdo changes on falling tck
// - steady states: reset, idle, shift-dr, pause-dr, shift-ir, pause-ir
// - tms held high reaches test-logic-reset within five tck edges
// - controller starts in test-logic-reset after reset
// - reset leads to idle; idle only launches the held nonvolatile op until a scan
// - data and instruction branches share one sequence; capture comes first
// - capture-dr parallel loads the data register chosen by the instruction
// - reset loads the id instruction so a blind data scan reads the id; capture-ir loads it too
// - capture goes to shift or exit1 per tms
// - shift goes through exit1 then update to idle, or to pause
// - pause holds contents; exit2 returns to shift or goes through update
// - program, lock, erase, signature program and verify start on the second rising tck spent in idle
// - all other instructions act in the update state
// - held instruction picks the data register between tdi and tdo
// - 32-bit user signature word is programmed and read through the port
// - with readout lock set, configuration data reads back as zeros
// - readout lock clears only through a bulk erase or the system reset
// - the four link wires are the only programming path
// - eight-bit instruction register; all ones selects one-bit bypass
// - code 16 hex selects the 32-bit identification register
// - sample/preload and all-zeros external test behave as bypass
// - nonvolatile write on second rising tck in idle, only in program mode
`timescale 1ns/1ns
`default_nettype none
`include "jcpp_regs.svh"

module jcpp_tap #(
	parameter int          ADDR_W  = 8,
	parameter int          DATA_W  = 16,
	parameter int          DEPTH   = 16,
	// identification word: value is arbitrary
	parameter logic [31:0] ID_WORD = 32'h0A5C3001
) (
	// system side
	input  wire logic         clk,
	input  wire logic         nrst,
	// four-wire test link
	input  wire logic         tck,
	input  wire logic         tms,
	input  wire logic         tdi,
	output logic              tdo,
	output logic              tdo_oe,
	// status
	output logic              readout_lock_bit,
	output logic              nv_commit,
	output logic              prog_mode,
	output jcpp_pkg::jcpp_st_e tap_state
);
	import jcpp_pkg::*;

	localparam int IDX_W = $clog2(DEPTH);

	// ----------------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------------
	logic                  tck_nrst;
	jcpp_st_e              st_r, st_nxt;
	logic [`JCPP_IR_W-1:0] ir_r, ir_sh_r;
	jcpp_dsel_e            dsel;
	logic [4:0]            dr_top;
	logic [31:0]           dr_sh_r, shift_val;
	logic                  byp_r;
	logic [ADDR_W-1:0]     addr_r, pay_addr_r;
	logic [DATA_W-1:0]     data_r, pay_data_r, rd_copy_r;
	logic [31:0]           sig_stage_r, pay_sig_r, sig_copy_r;
	logic                  lock_copy_r;
	logic [1:0]            rti_cnt_r;
	jcpp_op_e              op_sel, pay_op_r;
	logic                  launch;
	logic                  req_tgl_r, done_s, done_seen_r;
	logic                  req_s, req_seen_r, go, done_tgl_r;
	logic [DATA_W-1:0]     mem_r [DEPTH];
	logic [DATA_W-1:0]     rd_word_r;
	logic [31:0]           nv_sig_r;
	logic [IDX_W-1:0]      idx;

	// link reset follows the system reset, brought over to tck
	jcpp_sync #(.WIDTH(1)) u_rst_sync (.clk(tck), .d(nrst), .q(tck_nrst));

	// ----------------------------------------------------------------------
	// controller
	// ----------------------------------------------------------------------
	always_comb begin
		unique case (st_r)
			st_reset:  st_nxt = tms ? st_reset  : st_idle;
			st_idle:   st_nxt = tms ? st_sel_dr : st_idle;
			st_sel_dr: st_nxt = tms ? st_sel_ir : st_cap_dr;
			st_cap_dr: st_nxt = tms ? st_ex1_dr : st_sh_dr;
			st_sh_dr:  st_nxt = tms ? st_ex1_dr : st_sh_dr;
			st_ex1_dr: st_nxt = tms ? st_upd_dr : st_pau_dr;
			st_pau_dr: st_nxt = tms ? st_ex2_dr : st_pau_dr;
			st_ex2_dr: st_nxt = tms ? st_upd_dr : st_sh_dr;
			st_upd_dr: st_nxt = tms ? st_sel_dr : st_idle;
			st_sel_ir: st_nxt = tms ? st_reset  : st_cap_ir;
			st_cap_ir: st_nxt = tms ? st_ex1_ir : st_sh_ir;
			st_sh_ir:  st_nxt = tms ? st_ex1_ir : st_sh_ir;
			st_ex1_ir: st_nxt = tms ? st_upd_ir : st_pau_ir;
			st_pau_ir: st_nxt = tms ? st_ex2_ir : st_pau_ir;
			st_ex2_ir: st_nxt = tms ? st_upd_ir : st_sh_ir;
			st_upd_ir: st_nxt = tms ? st_sel_dr : st_idle;
		endcase
	end

	always_ff @(posedge tck) begin
		if (!tck_nrst) begin
			st_r <= st_reset;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tap_state = st_r;

	// ----------------------------------------------------------------------
	// instruction register
	// ----------------------------------------------------------------------
	always_ff @(posedge tck) begin
		if (!tck_nrst || st_r == st_reset) begin
			ir_r    <= `JCPP_INS_IDCODE;
			ir_sh_r <= `JCPP_INS_IDCODE;
		end else begin
			unique case (st_r)
				st_cap_ir: ir_sh_r <= `JCPP_INS_IDCODE;
				st_sh_ir:  ir_sh_r <= {tdi, ir_sh_r[`JCPP_IR_W-1:1]};
				st_upd_ir: ir_r    <= ir_sh_r;
				default:   ir_r    <= ir_r;
			endcase
		end
	end

	// program mode is armed and disarmed as an update-time instruction
	always_ff @(posedge tck) begin
		if (!tck_nrst) begin
			prog_mode <= 1'b0;
		end else if (st_r == st_upd_ir) begin
			if (ir_sh_r == `JCPP_INS_PROG_EN) begin
				prog_mode <= 1'b1;
			end else if (ir_sh_r == `JCPP_INS_PROG_DIS) begin
				prog_mode <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------------
	// data path selection
	// ----------------------------------------------------------------------
	always_comb begin
		unique case (ir_r)
			`JCPP_INS_IDCODE:   dsel = sel_id;
			`JCPP_INS_SIG_READ,
			`JCPP_INS_SIG_PROG: dsel = sel_sig;
			`JCPP_INS_ADDR_SH:  dsel = sel_addr;
			`JCPP_INS_DATA_SH,
			`JCPP_INS_PROGRAM,
			`JCPP_INS_VERIFY:   dsel = sel_data;
			default:            dsel = sel_bypass;
		endcase
		unique case (dsel)
			sel_addr: dr_top = 5'(ADDR_W - 1);
			sel_data: dr_top = 5'(DATA_W - 1);
			sel_sig:  dr_top = 5'(`JCPP_SIG_LEN - 1);
			default:  dr_top = 5'(`JCPP_ID_LEN - 1);
		endcase
		shift_val         = dr_sh_r >> 1;
		shift_val[dr_top] = tdi;
	end

	// ----------------------------------------------------------------------
	// data registers
	// ----------------------------------------------------------------------
	always_ff @(posedge tck) begin
		if (!tck_nrst) begin
			dr_sh_r <= 32'h0;
			byp_r   <= 1'b0;
		end else if (st_r == st_cap_dr) begin
			byp_r <= 1'b0;
			unique case (dsel)
				sel_id:   dr_sh_r <= ID_WORD;
				sel_sig:  dr_sh_r <= sig_copy_r;
				sel_addr: dr_sh_r <= 32'(addr_r);
				sel_data: dr_sh_r <= lock_copy_r ? 32'h0 : 32'(rd_copy_r);
				default:  dr_sh_r <= dr_sh_r;
			endcase
		end else if (st_r == st_sh_dr) begin
			byp_r <= tdi;
			if (dsel != sel_bypass) begin
				dr_sh_r <= shift_val;
			end
		end
	end

	// update stores the shifted word where the instruction points
	always_ff @(posedge tck) begin
		if (!tck_nrst) begin
			addr_r      <= '0;
			data_r      <= '0;
			sig_stage_r <= 32'h0;
		end else if (st_r == st_upd_dr) begin
			if (ir_r == `JCPP_INS_ADDR_SH) begin
				addr_r <= dr_sh_r[ADDR_W-1:0];
			end
			if (ir_r == `JCPP_INS_DATA_SH) begin
				data_r <= dr_sh_r[DATA_W-1:0];
			end
			if (ir_r == `JCPP_INS_SIG_PROG) begin
				sig_stage_r <= dr_sh_r;
			end
		end
	end

	// ----------------------------------------------------------------------
	// serial output, changed on the falling edge
	// ----------------------------------------------------------------------
	always_ff @(negedge tck) begin
		if (!tck_nrst) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo_oe <= (st_r == st_sh_dr) || (st_r == st_sh_ir);
			if (st_r == st_sh_ir) begin
				tdo <= ir_sh_r[0];
			end else if (dsel == sel_bypass) begin
				tdo <= byp_r;
			end else begin
				tdo <= dr_sh_r[0];
			end
		end
	end

	// ----------------------------------------------------------------------
	// nonvolatile launch from run-test/idle
	// ----------------------------------------------------------------------
	always_comb begin
		unique case (ir_r)
			`JCPP_INS_PROGRAM:   op_sel = op_prog;
			`JCPP_INS_LOCK_PROG: op_sel = op_lock;
			`JCPP_INS_ERASE:     op_sel = op_erase;
			`JCPP_INS_SIG_PROG:  op_sel = op_sig;
			`JCPP_INS_VERIFY:    op_sel = op_verify;
			default:             op_sel = op_none;
		endcase
	end

	always_ff @(posedge tck) begin
		if (!tck_nrst || st_r != st_idle) begin
			rti_cnt_r <= 2'h0;
		end else if (rti_cnt_r != `JCPP_RTI_SAT_CNT) begin
			rti_cnt_r <= rti_cnt_r + 2'h1;
		end
	end

	// verify only reads, so it does not need program mode
	assign launch = (st_r == st_idle) && (rti_cnt_r == `JCPP_RTI_FIRE_CNT)
		&& (op_sel != op_none) && (prog_mode || op_sel == op_verify);

	// payload stays put until the next launch, many tck edges later
	always_ff @(posedge tck) begin
		if (!tck_nrst) begin
			req_tgl_r  <= 1'b0;
			pay_op_r   <= op_none;
			pay_addr_r <= '0;
			pay_data_r <= '0;
			pay_sig_r  <= 32'h0;
		end else if (launch) begin
			req_tgl_r  <= ~req_tgl_r;
			pay_op_r   <= op_sel;
			pay_addr_r <= addr_r;
			pay_data_r <= data_r;
			pay_sig_r  <= sig_stage_r;
		end
	end

	// results are copied only after the done toggle lands; they are stable then
	jcpp_sync #(.WIDTH(1)) u_done_sync (.clk(tck), .d(done_tgl_r), .q(done_s));

	always_ff @(posedge tck) begin
		if (!tck_nrst) begin
			done_seen_r <= 1'b0;
			sig_copy_r  <= `JCPP_SIG_ERASED;
			lock_copy_r <= `JCPP_LOCK_RST;
			rd_copy_r   <= {DATA_W{`JCPP_ERASED_BIT}};
		end else if (done_s != done_seen_r) begin
			done_seen_r <= done_s;
			sig_copy_r  <= nv_sig_r;
			lock_copy_r <= readout_lock_bit;
			rd_copy_r   <= rd_word_r;
		end
	end

	// ----------------------------------------------------------------------
	// nonvolatile cells on the system clock
	// ----------------------------------------------------------------------
	jcpp_sync #(.WIDTH(1)) u_req_sync (.clk(clk), .d(req_tgl_r), .q(req_s));

	assign go  = req_s != req_seen_r;
	assign idx = pay_addr_r[IDX_W-1:0];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			req_seen_r <= 1'b0;
			done_tgl_r <= 1'b0;
			nv_commit  <= 1'b0;
		end else begin
			req_seen_r <= req_s;
			nv_commit  <= go && (pay_op_r != op_verify);
			if (go) begin
				done_tgl_r <= ~done_tgl_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || (go && pay_op_r == op_erase)) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= {DATA_W{`JCPP_ERASED_BIT}};
			end
		end else if (go && pay_op_r == op_prog) begin
			mem_r[idx] <= pay_data_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || (go && pay_op_r == op_erase)) begin
			nv_sig_r <= `JCPP_SIG_ERASED;
		end else if (go && pay_op_r == op_sig) begin
			nv_sig_r <= pay_sig_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			readout_lock_bit <= `JCPP_LOCK_RST;
		end else if (go && pay_op_r == op_erase) begin
			readout_lock_bit <= 1'b0;
		end else if (go && pay_op_r == op_lock) begin
			readout_lock_bit <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rd_word_r <= {DATA_W{`JCPP_ERASED_BIT}};
		end else if (go && pay_op_r == op_verify) begin
			rd_word_r <= mem_r[idx];
		end
	end

	// ----------------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------------
	property p_tms_reset;
		@(posedge tck) disable iff (!tck_nrst) tms [*5] |=> st_r == st_reset;
	endproperty
	a_tms_reset: assert property (p_tms_reset) else $error("five tms highs missed reset");

	property p_reset_exit;
		@(posedge tck) disable iff (!tck_nrst)
			st_r == st_reset |=> (st_r == st_reset) == $past(tms);
	endproperty
	a_reset_exit: assert property (p_reset_exit) else $error("bad exit from reset state");

	property p_capture_ir;
		@(posedge tck) disable iff (!tck_nrst) st_r == st_cap_ir |=> ir_sh_r == `JCPP_INS_IDCODE;
	endproperty
	a_capture_ir: assert property (p_capture_ir) else $error("capture-ir missed id code");

	property p_update_ir;
		@(posedge tck) disable iff (!tck_nrst) st_r == st_upd_ir |=> ir_r == $past(ir_sh_r);
	endproperty
	a_update_ir: assert property (p_update_ir) else $error("update-ir did not load");

	property p_capture_next;
		@(posedge tck) disable iff (!tck_nrst)
			st_r == st_cap_dr |=> st_r == ($past(tms) ? st_ex1_dr : st_sh_dr);
	endproperty
	a_capture_next: assert property (p_capture_next) else $error("bad step after capture");

	property p_pause_hold;
		@(posedge tck) disable iff (!tck_nrst) st_r == st_pau_dr |=> $stable(dr_sh_r);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("data moved in pause");

	property p_launch_edge;
		@(posedge tck) disable iff (!tck_nrst)
			launch |-> $past(st_r) == st_idle && $past(st_r, 2) != st_idle;
	endproperty
	a_launch_edge: assert property (p_launch_edge) else $error("launch not on second idle edge");

	property p_launch_mode;
		@(posedge tck) disable iff (!tck_nrst) $changed(req_tgl_r) && pay_op_r != op_verify |-> $past(prog_mode);
	endproperty
	a_launch_mode: assert property (p_launch_mode) else $error("write without program mode");

	property p_lock_read;
		@(posedge tck) disable iff (!tck_nrst)
			st_r == st_cap_dr && dsel == sel_data && lock_copy_r |=> dr_sh_r == 32'h0;
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("locked data was read");

	property p_oe_shift;
		@(posedge tck) disable iff (!tck_nrst)
			$past(tck_nrst) |-> tdo_oe == (st_r == st_sh_dr || st_r == st_sh_ir);
	endproperty
	a_oe_shift: assert property (p_oe_shift) else $error("tdo enable outside shift");

	property p_lock_clear;
		@(posedge clk) disable iff (!nrst)
			$fell(readout_lock_bit) |-> $past(go) && $past(pay_op_r) == op_erase;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock cleared without erase");

	c_id_scan: cover property (@(posedge tck) st_r == st_cap_dr && dsel == sel_id);
	c_launch:  cover property (@(posedge tck) launch && op_sel == op_prog);
	c_pause:   cover property (@(posedge tck) st_r == st_ex2_dr ##1 st_r == st_sh_dr);
	c_locked:  cover property (@(posedge clk) $rose(readout_lock_bit));

endmodule // jcpp_tap

`default_nettype wire

// [verification/jcpp_host.sv]
// programming host model: drives the four-wire link, tck only while a step runs (scans and idle)
// assumes the port samples on rising tck and updates tdo on falling tck
`timescale 1ns/1ns
`default_nettype none

module jcpp_host (
	// link towards the port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	// link from the port
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	localparam int HALF = 24;

	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// --------------------------------------------------------------------------
	// one tck period
	// --------------------------------------------------------------------------
	// levels change while tck is low, tdo is taken at the rising edge
	task automatic step(input logic m, input logic d, output logic q, output logic oe);
		tms = m;
		tdi = d;
		#HALF;
		tck = 1'b1;
		// a released tdo shows inverted, so a read outside shift cannot pass
		q = tdo_oe ? tdo : ~tdo;
		oe = tdo_oe;
		#HALF;
		tck = 1'b0;
	endtask

	task automatic idle(input int n);
		logic q;
		logic oe;
		repeat (n) step(1'b0, 1'b0, q, oe);
	endtask

	// --------------------------------------------------------------------------
	// full scan from idle back to idle, lsb first
	// --------------------------------------------------------------------------
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout, output logic oe_ok);
		logic q;
		logic oe;
		dout = 32'h0;
		oe_ok = 1'b1;
		step(1'b1, 1'b0, q, oe);
		if (ir) begin
			step(1'b1, 1'b0, q, oe);
		end
		step(1'b0, 1'b0, q, oe);
		step(1'b0, 1'b0, q, oe);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q, oe);
			dout[i] = q;
			oe_ok &= oe;
		end
		step(1'b1, 1'b0, q, oe);
		step(1'b0, 1'b0, q, oe);
	endtask
endmodule // jcpp_host

`default_nettype wire

// [verification/jcpp_tap_bench.sv]
// self-checking bench of the serial configuration port
// assumes jcpp_pkg and jcpp_host are compiled before it
`timescale 1ns/1ns
`default_nettype none

module jcpp_tap_bench;
	import jcpp_pkg::*;
	// identification word: value is arbitrary
	localparam logic [31:0] ID_EXP = 32'h0A5C3001;
	localparam logic [31:0] SIG    = 32'h3C5A96E1;

	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	wire         tck;
	wire         tms;
	wire         tdi;
	logic        tdo;
	logic        tdo_oe;
	logic        lock;
	logic        nv_commit;
	logic        prog_mode;
	jcpp_st_e    tap_state;
	int          err_count = 0;
	int          checks = 0;
	int          cycles = 0;
	logic        commit_seen = 1'b0;
	logic [31:0] d;
	logic        ok;
	logic        hq;
	logic        hoe;

	always #50 clk = ~clk;

	jcpp_tap i_dut (
		.clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .readout_lock_bit(lock), .nv_commit(nv_commit),
		.prog_mode(prog_mode), .tap_state(tap_state));

	jcpp_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	always @(posedge clk) begin
		if (nv_commit === 1'b1) begin
			commit_seen = 1'b1;
		end
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// --------------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic ir(input logic [7:0] code);
		i_host.scan(1'b1, 8, {24'h0, code}, d, ok);
	endtask

	task automatic dr(input int n, input logic [31:0] v);
		i_host.scan(1'b0, n, v, d, ok);
	endtask

	// verify reads back the word at address 5
	task automatic rd();
		ir(8'h01);
		dr(8, 32'h5);
		ir(8'h0A);
		i_host.idle(30);
		dr(16, 32'h0);
	endtask

	// --------------------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------------------
	task automatic t_reset();
		fork
			repeat (8) @(posedge clk);
			repeat (6) i_host.step(1'b1, 1'b0, hq, hoe);
		join
		#5 nrst = 1'b1;
		repeat (3) i_host.step(1'b1, 1'b0, hq, hoe);
		chk(tap_state, st_reset, "state after reset");
		chk(tdo_oe, 1'b0, "tdo driven in reset");
		i_host.step(1'b0, 1'b0, hq, hoe);
		chk(tap_state, st_idle, "state after leaving reset");
	endtask

	task automatic t_idcode();
		dr(32, 32'h0);
		chk(d, ID_EXP, "blind data scan");
		chk(ok, 1'b1, "tdo released in shift");
		chk(tdo_oe, 1'b0, "tdo driven in idle");
		ir(8'h16);
		chk(d[7:0], 8'h16, "captured instruction");
	endtask

	// id scan split by a pause halfway; pause must hold the shifted bits
	task automatic t_pause();
		i_host.step(1'b1, 1'b0, hq, hoe);
		i_host.step(1'b0, 1'b0, hq, hoe);
		i_host.step(1'b0, 1'b0, hq, hoe);
		d = 32'h0;
		for (int i = 0; i < 32; i++) begin
			i_host.step(i == 15 || i == 31, 1'b0, hq, hoe);
			d[i] = hq;
			if (i == 15) begin
				i_host.step(1'b0, 1'b0, hq, hoe);
				i_host.step(1'b0, 1'b0, hq, hoe);
				chk(tap_state, st_pau_dr, "pause is not steady");
				i_host.step(1'b1, 1'b0, hq, hoe);
				i_host.step(1'b0, 1'b0, hq, hoe);
			end
		end
		i_host.step(1'b1, 1'b0, hq, hoe);
		i_host.step(1'b0, 1'b0, hq, hoe);
		chk(d, ID_EXP, "id scan across a pause");
	endtask

	task automatic t_bypass();
		logic [7:0] codes [4] = '{8'hFF, 8'h00, 8'h1C, 8'h5A};
		foreach (codes[k]) begin
			ir(codes[k]);
			dr(8, 32'hB4);
			chk(d[7:0], 8'h68, "one-bit bypass path");
		end
	endtask

	task automatic t_tlr();
		i_host.step(1'b1, 1'b0, hq, hoe);
		i_host.step(1'b0, 1'b0, hq, hoe);
		i_host.step(1'b0, 1'b0, hq, hoe);
		#1;
		chk(tdo_oe, 1'b1, "tdo not driven in shift");
		repeat (5) i_host.step(1'b1, 1'b0, hq, hoe);
		chk(tap_state, st_reset, "five tms high");
		i_host.step(1'b0, 1'b0, hq, hoe);
	endtask

	task automatic t_sig();
		ir(8'h15);
		chk(prog_mode, 1'b1, "program mode on");
		ir(8'h1A);
		dr(32, SIG);
		commit_seen = 1'b0;
		i_host.idle(30);
		chk(commit_seen, 1'b1, "signature commit");
		ir(8'h17);
		dr(32, 32'h0);
		chk(d, SIG, "signature readback");
		ir(8'h1E);
		chk(prog_mode, 1'b0, "program mode off");
		ir(8'h1A);
		dr(32, 32'h0);
		commit_seen = 1'b0;
		i_host.idle(30);
		chk(commit_seen, 1'b0, "commit without program mode");
	endtask

	task automatic t_data();
		ir(8'h15);
		ir(8'h01);
		dr(8, 32'h5);
		ir(8'h02);
		dr(16, 32'hA55A);
		ir(8'h07);
		i_host.idle(30);
		rd();
		chk(d[15:0], 16'hA55A, "programmed word");
		ir(8'h09);
		i_host.idle(30);
		chk(lock, 1'b1, "lock set");
		rd();
		chk(d[15:0], 16'h0000, "readout while locked");
		ir(8'h03);
		i_host.idle(30);
		chk(lock, 1'b0, "lock after erase");
		rd();
		chk(d[15:0], 16'hFFFF, "erased word");
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		t_reset();
		t_idcode();
		t_pause();
		t_bypass();
		t_tlr();
		t_sig();
		t_data();
		tally_and_finish();
	end
endmodule // jcpp_tap_bench

`default_nettype wire
